// [common/cmo_pkg.sv]
// Shared constants and types for the move, OR and return-with-literal execute block
//
// What this block does
// - OR accumulator with file 0..31 to accumulator (dest 0) or file (dest 1), update zero.
// - Store the accumulator into file register 0..31 and leave every flag alone.
// - Move file 0..31 to accumulator (dest 0) or into itself (dest 1); zero from the value.
// - Move-file write-back still updates zero, testing a register without changing it.
// - Load the 8-bit literal into the accumulator and leave every flag alone.
// - Load the option register with the whole accumulator and leave every flag alone.
// - Return loads the literal into accumulator and the stack top into PC, flags untouched.
// - Return takes two instruction cycles; the already fetched next word is discarded.
package cmo_pkg;

  // ---------------------------------------------------------------
  // Instruction word layout
  // ---------------------------------------------------------------
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int FADDR_LSB = 0;
  localparam int DEST_BIT = 5;
  localparam int LIT_LSB = 0;
  localparam int OP6_LSB = 6;
  localparam int OP7_LSB = 5;
  localparam int OP4_LSB = 8;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
  localparam logic ZERO_RST = 1'b0;

  // Cycles spent by the return-with-literal instruction
  localparam int RETURN_CYCLES = 2;

  // Execute sequencer states
  typedef enum logic [0:0] {
    CMO_RUN,
    CMO_DISCARD
  } cmo_state_t;

  // Class of the instruction just executed
  typedef enum logic [2:0] {
    CMO_OP_NONE,
    CMO_OP_OR_FILE,
    CMO_OP_STORE,
    CMO_OP_MOVE_FILE,
    CMO_OP_LOAD_LIT,
    CMO_OP_LOAD_OPTION,
    CMO_OP_RETURN,
    CMO_OP_NOP
  } cmo_op_t;

  // File register write port
  typedef struct packed {
    logic we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmo_file_wr_t;

  // Program counter load, advance and pop request
  typedef struct packed {
    logic load;
    logic advance;
    logic pop;
  } cmo_pc_ctl_t;

endpackage

// [hw/cmo_exec.sv]
// Execute stage for OR-with-file, moves, literal load, option load, no-op and return
`timescale 1ns/100ps

module cmo_exec #(
  parameter int PC_W = 9,
  // Opcode patterns; defaults follow the usual 12-bit baseline encoding
  parameter logic [5:0] OPC_OR_FILE = 6'h04,
  parameter logic [5:0] OPC_MOVE_FILE = 6'h08,
  parameter logic [6:0] OPC_STORE = 7'h01,
  parameter logic [3:0] OPC_LOAD_LIT = 4'hC,
  parameter logic [3:0] OPC_RETURN = 4'h8,
  parameter logic [11:0] OPC_NOP = 12'h000,
  parameter logic [11:0] OPC_OPTION = 12'h002
) (
  input wire logic clock,
  input wire logic rst,
  // Fetched instruction, one per clock while valid
  input wire logic instr_valid,
  input wire logic [cmo_pkg::INSTR_W-1:0] instr,
  // Read data of the file register named by instr, same cycle
  input wire logic [cmo_pkg::DATA_W-1:0] file_rdata,
  // Return address at the top of the hardware stack
  input wire logic [PC_W-1:0] stack_top,
  // File register write port
  output cmo_pkg::cmo_file_wr_t file_wr_q,
  // Accumulator, zero flag and option register
  output logic [cmo_pkg::DATA_W-1:0] accum_q,
  output logic zero_q,
  output logic zero_upd_q,
  output logic [cmo_pkg::DATA_W-1:0] option_q,
  // Program counter control
  output cmo_pkg::cmo_pc_ctl_t pc_ctl_q,
  output logic [PC_W-1:0] pc_target_q,
  // Sequencer status
  output logic discard_q,
  output cmo_pkg::cmo_op_t last_op_q,
  output logic unhandled_q
);

  // ---------------------------------------------------------------
  // Instruction field extraction
  // ---------------------------------------------------------------
  logic [5:0] op6;
  logic [6:0] op7;
  logic [3:0] op4;
  logic dest;
  logic [cmo_pkg::FADDR_W-1:0] faddr;
  logic [cmo_pkg::DATA_W-1:0] literal;

  // Slices of the instruction word
  assign op6 = instr[cmo_pkg::OP6_LSB +: 6];
  assign op7 = instr[cmo_pkg::OP7_LSB +: 7];
  assign op4 = instr[cmo_pkg::OP4_LSB +: 4];
  assign dest = instr[cmo_pkg::DEST_BIT];
  assign faddr = instr[cmo_pkg::FADDR_LSB +: cmo_pkg::FADDR_W];
  assign literal = instr[cmo_pkg::LIT_LSB +: cmo_pkg::DATA_W];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  cmo_pkg::cmo_op_t op;

  // Classify the fetched word; full-word patterns are checked first
  always_comb begin
    if (instr == OPC_NOP) begin
      op = cmo_pkg::CMO_OP_NOP;
    end else if (instr == OPC_OPTION) begin
      op = cmo_pkg::CMO_OP_LOAD_OPTION;
    end else if (op6 == OPC_OR_FILE) begin
      op = cmo_pkg::CMO_OP_OR_FILE;
    end else if (op6 == OPC_MOVE_FILE) begin
      op = cmo_pkg::CMO_OP_MOVE_FILE;
    end else if (op7 == OPC_STORE) begin
      op = cmo_pkg::CMO_OP_STORE;
    end else if (op4 == OPC_LOAD_LIT) begin
      op = cmo_pkg::CMO_OP_LOAD_LIT;
    end else if (op4 == OPC_RETURN) begin
      op = cmo_pkg::CMO_OP_RETURN;
    end else begin
      op = cmo_pkg::CMO_OP_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Execute state
  // ---------------------------------------------------------------
  cmo_pkg::cmo_state_t state_q;
  cmo_pkg::cmo_state_t state_d;
  cmo_pkg::cmo_file_wr_t file_wr_d;
  logic [cmo_pkg::DATA_W-1:0] accum_d;
  logic zero_d;
  logic zero_upd_d;
  logic [cmo_pkg::DATA_W-1:0] option_d;
  cmo_pkg::cmo_pc_ctl_t pc_ctl_d;
  logic [PC_W-1:0] pc_target_d;
  logic discard_d;
  cmo_pkg::cmo_op_t last_op_d;
  logic unhandled_d;
  logic [cmo_pkg::DATA_W-1:0] or_result;

  // OR of accumulator and the addressed file register
  assign or_result = accum_q | file_rdata;

  // Next values of all architectural state and pulses
  always_comb begin
    state_d = state_q;
    file_wr_d = '0;
    accum_d = accum_q;
    zero_d = zero_q;
    zero_upd_d = 1'b0;
    option_d = option_q;
    pc_ctl_d = '0;
    pc_target_d = pc_target_q;
    discard_d = 1'b0;
    last_op_d = last_op_q;
    unhandled_d = 1'b0;
    case (state_q)
      cmo_pkg::CMO_RUN: begin
        if (instr_valid) begin
          last_op_d = op;
          pc_ctl_d.advance = 1'b1;
          case (op)
            cmo_pkg::CMO_OP_OR_FILE: begin
              if (dest) begin
                file_wr_d.we = 1'b1;
                file_wr_d.addr = faddr;
                file_wr_d.data = or_result;
              end else begin
                accum_d = or_result;
              end
              zero_d = (or_result == '0);
              zero_upd_d = 1'b1;
            end
            cmo_pkg::CMO_OP_STORE: begin
              // Flags deliberately untouched
              file_wr_d.we = 1'b1;
              file_wr_d.addr = faddr;
              file_wr_d.data = accum_q;
            end
            cmo_pkg::CMO_OP_MOVE_FILE: begin
              if (dest) begin
                // Rewrite the same value so the register is unchanged
                file_wr_d.we = 1'b1;
                file_wr_d.addr = faddr;
                file_wr_d.data = file_rdata;
              end else begin
                accum_d = file_rdata;
              end
              // Zero follows the moved value in both forms
              zero_d = (file_rdata == '0);
              zero_upd_d = 1'b1;
            end
            cmo_pkg::CMO_OP_LOAD_LIT: begin
              accum_d = literal;
            end
            cmo_pkg::CMO_OP_LOAD_OPTION: begin
              option_d = accum_q;
            end
            cmo_pkg::CMO_OP_RETURN: begin
              accum_d = literal;
              pc_ctl_d.advance = 1'b0;
              pc_ctl_d.load = 1'b1;
              pc_ctl_d.pop = 1'b1;
              pc_target_d = stack_top;
              // Second cycle throws away the prefetched word
              state_d = cmo_pkg::CMO_DISCARD;
            end
            cmo_pkg::CMO_OP_NOP: begin
              // Only the program counter moves on
              pc_ctl_d.advance = 1'b1;
            end
            default: begin
              // Not executed here; another unit owns it
              unhandled_d = 1'b1;
            end
          endcase
        end
      end
      cmo_pkg::CMO_DISCARD: begin
        // Prefetched word is dropped as a forced no-op
        discard_d = 1'b1;
        last_op_d = cmo_pkg::CMO_OP_NONE;
        state_d = cmo_pkg::CMO_RUN;
      end
      default: begin
        state_d = cmo_pkg::CMO_RUN;
      end
    endcase
  end

  // Register all state and outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= cmo_pkg::CMO_RUN;
      file_wr_q <= '0;
      accum_q <= cmo_pkg::ACC_RST;
      zero_q <= cmo_pkg::ZERO_RST;
      zero_upd_q <= 1'b0;
      option_q <= cmo_pkg::OPTION_RST;
      pc_ctl_q <= '0;
      pc_target_q <= '0;
      discard_q <= 1'b0;
      last_op_q <= cmo_pkg::CMO_OP_NONE;
      unhandled_q <= 1'b0;
    end else begin
      state_q <= state_d;
      file_wr_q <= file_wr_d;
      accum_q <= accum_d;
      zero_q <= zero_d;
      zero_upd_q <= zero_upd_d;
      option_q <= option_d;
      pc_ctl_q <= pc_ctl_d;
      pc_target_q <= pc_target_d;
      discard_q <= discard_d;
      last_op_q <= last_op_d;
      unhandled_q <= unhandled_d;
    end
  end

endmodule // cmo_exec

// [testbench/cmo_exec_asserts.sv]
// Port assertions for the execute block
`timescale 1ns/100ps
module cmo_exec_asserts #(
  parameter int PC_W = 9
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [cmo_pkg::INSTR_W-1:0] instr,
  input wire logic [cmo_pkg::DATA_W-1:0] file_rdata,
  input wire logic [PC_W-1:0] stack_top,
  input wire cmo_pkg::cmo_file_wr_t file_wr_q,
  input wire logic [cmo_pkg::DATA_W-1:0] accum_q,
  input wire logic zero_q,
  input wire logic zero_upd_q,
  input wire logic [cmo_pkg::DATA_W-1:0] option_q,
  input wire cmo_pkg::cmo_pc_ctl_t pc_ctl_q,
  input wire logic [PC_W-1:0] pc_target_q,
  input wire logic discard_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Word taken this edge: valid and not the slot after a return
  wire logic tk = instr_valid && !pc_ctl_q.pop;
  sequence s_ret;
    tk && instr[11:8] == 4'h8;
  endsequence
  sequence s_ret_ans;
    pc_ctl_q == 3'h5 && pc_target_q == $past(stack_top) && accum_q == $past(instr[7:0]);
  endsequence
  property p_or;
    tk && instr[11:6] == 6'h04 |=> zero_upd_q &&
      zero_q == (($past(accum_q) | $past(file_rdata)) == 8'h00);
  endproperty
  a_or: assert property (p_or) else $error("or zero wrong");
  property p_or_dst;
    tk && instr[11:5] == 7'h09 |=> file_wr_q.we &&
      file_wr_q.data == ($past(accum_q) | $past(file_rdata)) && $stable(accum_q);
  endproperty
  a_or_dst: assert property (p_or_dst) else $error("or file write wrong");
  property p_store;
    tk && instr[11:5] == 7'h01 |=>
      file_wr_q == {1'b1, $past(instr[4:0]), $past(accum_q)} && !zero_upd_q;
  endproperty
  a_store: assert property (p_store) else $error("store wrong");
  property p_move;
    tk && instr[11:6] == 6'h08 |=> zero_upd_q && zero_q == ($past(file_rdata) == 8'h00);
  endproperty
  a_move: assert property (p_move) else $error("move zero wrong");
  property p_lit;
    tk && instr[11:8] == 4'hC |=> accum_q == $past(instr[7:0]) && !zero_upd_q && $stable(zero_q);
  endproperty
  a_lit: assert property (p_lit) else $error("literal wrong");
  property p_opt;
    tk && instr == 12'h002 |=> option_q == $past(accum_q) && $stable(zero_q);
  endproperty
  a_opt: assert property (p_opt) else $error("option wrong");
  property p_ret;
    s_ret |=> s_ret_ans ##1 discard_q && $stable(accum_q) && !zero_upd_q;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_nop;
    tk && instr == 12'h000 |=> pc_ctl_q == 3'h2 && !file_wr_q.we &&
      $stable(accum_q) && !zero_upd_q;
  endproperty
  a_nop: assert property (p_nop) else $error("nop wrong");
endmodule // cmo_exec_asserts
bind cmo_exec cmo_exec_asserts #(.PC_W(PC_W)) cmo_exec_asserts_inst (.clock(clock), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata), .stack_top(stack_top),
  .file_wr_q(file_wr_q), .accum_q(accum_q), .zero_q(zero_q), .zero_upd_q(zero_upd_q),
  .option_q(option_q), .pc_ctl_q(pc_ctl_q), .pc_target_q(pc_target_q), .discard_q(discard_q));

// [testbench/tb.sv]
// Testbench for the execute block
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [8:0] stack_top = 9'h000;
  cmo_pkg::cmo_file_wr_t file_wr_q;
  cmo_pkg::cmo_pc_ctl_t pc_ctl_q;
  cmo_pkg::cmo_op_t last_op_q;
  logic [7:0] accum_q, option_q;
  logic [8:0] pc_target_q;
  logic zero_q, zero_upd_q, discard_q, unhandled_q;
  int failures = 0;
  int checked = 0;
  always #25 clock = ~clock;
  cmo_exec cmo_exec_inst (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .stack_top(stack_top), .file_wr_q(file_wr_q), .accum_q(accum_q),
    .zero_q(zero_q), .zero_upd_q(zero_upd_q), .option_q(option_q), .pc_ctl_q(pc_ctl_q),
    .pc_target_q(pc_target_q), .discard_q(discard_q), .last_op_q(last_op_q),
    .unhandled_q(unhandled_q));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One instruction, outputs settled on return
  task automatic op(input logic [11:0] w, input logic [7:0] rd);
    @(posedge clock);
    #1;
    instr_valid = 1'b1;
    instr = w;
    file_rdata = rd;
    @(posedge clock);
    #1;
    instr_valid = 1'b0;
  endtask
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic t_or();
    op(12'hCA5, 8'h00);
    op(12'h105, 8'h50);
    chk("accum", 16'h00F5, accum_q);
    chk("zero", 16'h0000, zero_q);
    op(12'hC00, 8'h00);
    op(12'h13F, 8'h00);
    chk("file_wr", 16'h3F00, file_wr_q);
    chk("zero", 16'h0001, zero_q);
    $display("t_or done");
  endtask
  task automatic t_lit_store();
    op(12'hCA5, 8'h00);
    chk("accum", 16'h00A5, accum_q);
    chk("zero", 16'h0001, zero_q);
    op(12'h02A, 8'h00);
    chk("file_wr", 16'h2AA5, file_wr_q);
    chk("zero_upd", 16'h0000, zero_upd_q);
    $display("t_lit_store done");
  endtask
  task automatic t_move();
    op(12'h203, 8'h00);
    chk("accum", 16'h0000, accum_q);
    op(12'h23E, 8'h80);
    chk("file_wr", 16'h3E80, file_wr_q);
    chk("zero", 16'h0000, zero_q);
    chk("accum", 16'h0000, accum_q);
    $display("t_move done");
  endtask
  task automatic t_opt_nop();
    op(12'hC5A, 8'h00);
    op(12'h002, 8'h00);
    chk("option", 16'h005A, option_q);
    op(12'h000, 8'h00);
    chk("pc_ctl", 16'h0002, pc_ctl_q);
    chk("file_we", 16'h0000, file_wr_q.we);
    chk("accum", 16'h005A, accum_q);
    chk("unhandled", 16'h0000, unhandled_q);
    chk("last_op", cmo_pkg::CMO_OP_NOP, last_op_q);
    $display("t_opt_nop done");
  endtask
  // Return followed at once by a word that must be dropped
  task automatic t_ret();
    stack_top = 9'h1AB;
    @(posedge clock);
    #1;
    instr_valid = 1'b1;
    instr = 12'h87E;
    @(posedge clock);
    #1;
    instr = 12'hC33;
    chk("pc_ctl", 16'h0005, pc_ctl_q);
    chk("pc_target", 16'h01AB, pc_target_q);
    chk("accum", 16'h007E, accum_q);
    chk("last_op", cmo_pkg::CMO_OP_RETURN, last_op_q);
    @(posedge clock);
    #1;
    instr_valid = 1'b0;
    chk("discard", 16'h0001, discard_q);
    chk("accum", 16'h007E, accum_q);
    chk("last_op", cmo_pkg::CMO_OP_NONE, last_op_q);
    $display("t_ret done");
  endtask
  initial begin
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("option", 16'h00FF, option_q);
    t_or();
    t_lit_store();
    t_move();
    t_opt_nop();
    t_ret();
    results();
  end
  // Watchdog against a hang
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule // tb
